// ### dcs_pkg.sv
// constants, types and register map of the drive command source selector
package dcs_pkg;

  localparam int SPD_W  = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STEP_N = 4;
  localparam int ERR_W  = 3;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_MODE_SEL  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PANEL_SPD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_JOG_SPD   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STOP_CFG  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ERROR     = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STEP_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_STEP_MASK = 8'hF3;
  localparam int                STEP_IDX_LSB   = 2;

  // mode_select_setting values
  localparam logic [2:0] SEL_TOGGLE    = 3'h0;
  localparam logic [2:0] SEL_PANEL     = 3'h1;
  localparam logic [2:0] SEL_TERM      = 3'h2;
  localparam logic [2:0] SEL_COMB1     = 3'h3;
  localparam logic [2:0] SEL_COMB2     = 3'h4;
  localparam logic [2:0] SEL_SWITCH    = 3'h6;
  localparam logic [2:0] SEL_INTERLOCK = 3'h7;
  localparam logic [2:0] SEL_RST       = SEL_TOGGLE;

  // reset values
  localparam logic [SPD_W-1:0] SPD_RST      = 16'h0000;
  localparam logic             STOP_ALL_RST = 1'b1;

  // network message kinds and mode codes
  localparam logic [1:0] NET_KIND_MODE  = 2'h0;
  localparam logic [1:0] NET_KIND_RUN   = 2'h1;
  localparam logic [1:0] NET_KIND_SPEED = 2'h2;
  localparam logic [1:0] NET_CODE_TERM  = 2'h0;
  localparam logic [1:0] NET_CODE_PANEL = 2'h1;
  localparam logic [1:0] NET_CODE_NET   = 2'h2;

  // status and error field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_FWD      = 4;
  localparam int ST_REV      = 5;
  localparam int ST_STOP     = 6;
  localparam int ST_RUNNING  = 7;
  localparam int ST_SEL_LSB  = 8;
  localparam int ERR_SEL     = 0;
  localparam int ERR_LOCK    = 1;
  localparam int ERR_MODE    = 2;
  localparam int STOP_ALL    = 0;

  typedef enum logic [2:0] {
    MODE_TERM,
    MODE_PANEL,
    MODE_NET,
    MODE_COMB1,
    MODE_COMB2
  } dcs_mode_t;

  typedef struct packed {
    logic forward_run_input;
    logic reverse_run_input;
    logic speed_step_low_input;
    logic speed_step_mid_input;
    logic speed_step_high_input;
    logic speed_step_extra_input;
    logic process_loop_enable_input;
    logic analog_four_select_input;
    logic inching_input;
    logic panel_interlock_input;
    logic panel_mode_key;
    logic panel_run_key;
    logic panel_stop_key;
    logic panel_dir_rev;
  } dcs_pins_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dcs_bus_req_t;

  typedef struct packed {
    logic             valid;
    logic [1:0]       kind;
    logic [SPD_W-1:0] data;
  } dcs_net_msg_t;

endpackage

// ### dcs_sync.sv
// two-stage synchroniser for a vector of pin inputs
module dcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clock_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end
      else
      begin
        meta_q[i] <= d_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign q_o = sync_q;

endmodule

// ### dcs_source_select.sv
// drive command source selector: operation mode, run source and speed reference
//
// Operation
// - In combined mode one the speed comes from step inputs, then process loop, then analog four, then panel setting.
// - The current operation mode picks where both run command and speed reference come from.
// - Terminal mode runs from the forward and reverse inputs and takes speed from analog, step or inching inputs.
// - Network mode takes run command and speed reference from serial messages.
// - Mode select 0 or 2 starts the device in terminal mode.
// - Mode select 2 keeps terminal or network mode and the panel mode key cannot reach panel mode.
// - Mode select 0 (reset default) lets each panel mode key press toggle terminal and panel mode.
// - Mode select 1 enters panel mode and refuses every mode change request.
// - In terminal mode only a small subset of settings may be written.
// - The mode select setting is written only while the motor is stopped, in any mode.
// - By default the panel stop key acts in every operation mode.
// - Mode select 3 takes panel speed with terminal run, 4 takes terminal speed with panel run.
// - In panel mode serial speed messages set the panel speed and serial run messages are ignored.
// - The mode may be changed from the panel or by a serial mode code.
// - Mode select 6 allows switching among panel, terminal and network while running.
// - Mode select 7 forces terminal mode whenever the panel interlock input is inactive.
//
// The placing of the registers and the address-and-strobe port were decided locally.
module dcs_source_select (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire dcs_pkg::dcs_bus_req_t       bus_i,
  output logic      [dcs_pkg::DATA_W-1:0] rd_data_o,
  input  wire dcs_pkg::dcs_pins_t          pins_i,
  input  wire logic                        motor_running_i,
  input  wire dcs_pkg::dcs_net_msg_t       net_i,
  input  wire logic [dcs_pkg::SPD_W-1:0]  analog_two_i,
  input  wire logic [dcs_pkg::SPD_W-1:0]  analog_four_i,
  input  wire logic [dcs_pkg::SPD_W-1:0]  process_loop_speed_i,
  output dcs_pkg::dcs_mode_t               op_mode_o,
  output logic                             run_fwd_o,
  output logic                             run_rev_o,
  output logic      [dcs_pkg::SPD_W-1:0]  speed_ref_o
);
  import dcs_pkg::*;

  dcs_pins_t          pins_s;
  logic [2:0]         keys_prev_q;
  logic [2:0]         keys_prev_d;
  dcs_mode_t          mode_q;
  dcs_mode_t          mode_d;
  logic [2:0]         sel_q;
  logic [2:0]         sel_d;
  logic [SPD_W-1:0]   panel_spd_q;
  logic [SPD_W-1:0]   panel_spd_d;
  logic [SPD_W-1:0]   jog_spd_q;
  logic [SPD_W-1:0]   jog_spd_d;
  logic [SPD_W-1:0]   step_q [STEP_N];
  logic [SPD_W-1:0]   step_d [STEP_N];
  logic               stop_all_q;
  logic               stop_all_d;
  logic [ERR_W-1:0]   err_q;
  logic [ERR_W-1:0]   err_d;
  logic               pnl_fwd_q;
  logic               pnl_fwd_d;
  logic               pnl_rev_q;
  logic               pnl_rev_d;
  logic               net_fwd_q;
  logic               net_fwd_d;
  logic               net_rev_q;
  logic               net_rev_d;
  logic [SPD_W-1:0]   net_spd_q;
  logic [SPD_W-1:0]   net_spd_d;
  logic               stop_hold_q;
  logic               stop_hold_d;
  logic               run_fwd_q;
  logic               run_fwd_d;
  logic               run_rev_q;
  logic               run_rev_d;
  logic [SPD_W-1:0]   speed_q;
  logic [SPD_W-1:0]   speed_d;
  logic [DATA_W-1:0]  rd_data_q;
  logic [DATA_W-1:0]  rd_data_d;

  // every panel key and terminal pin is asynchronous to the controller clock
  dcs_sync #(
    .W ($bits(dcs_pins_t))
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     (pins_i),
    .q_o     (pins_s)
  );

  function automatic logic sel_legal(input logic [2:0] v);
    sel_legal = (v != 3'h5);
  endfunction

  function automatic dcs_mode_t sel_mode(input logic [2:0] v);
    case (v)
      SEL_PANEL: sel_mode = MODE_PANEL;
      SEL_COMB1: sel_mode = MODE_COMB1;
      SEL_COMB2: sel_mode = MODE_COMB2;
      default:   sel_mode = MODE_TERM;
    endcase
  endfunction

  always_comb
  begin
    logic             mode_key_p;
    logic             run_key_p;
    logic             stop_key_p;
    logic             req;
    logic             allowed;
    dcs_mode_t        target;
    logic             net_ok;
    logic             wr_sel;
    logic             term_lock;
    logic [3:0]       steps;
    logic             step_hit;
    logic [1:0]       step_idx;
    logic [SPD_W-1:0] term_spd;
    logic [SPD_W-1:0] comb1_spd;
    logic             cmd_f;
    logic             cmd_r;
    mode_key_p  = 1'b0;
    run_key_p   = 1'b0;
    stop_key_p  = 1'b0;
    req         = 1'b0;
    allowed     = 1'b0;
    target      = mode_q;
    net_ok      = 1'b0;
    wr_sel      = 1'b0;
    term_lock   = 1'b0;
    steps       = 4'h0;
    step_hit    = 1'b0;
    step_idx    = 2'h0;
    term_spd    = SPD_RST;
    comb1_spd   = SPD_RST;
    cmd_f       = 1'b0;
    cmd_r       = 1'b0;
    mode_d      = mode_q;
    sel_d       = sel_q;
    panel_spd_d = panel_spd_q;
    jog_spd_d   = jog_spd_q;
    step_d      = step_q;
    stop_all_d  = stop_all_q;
    err_d       = err_q;
    pnl_fwd_d   = pnl_fwd_q;
    pnl_rev_d   = pnl_rev_q;
    net_fwd_d   = net_fwd_q;
    net_rev_d   = net_rev_q;
    net_spd_d   = net_spd_q;
    rd_data_d   = '0;

    keys_prev_d = {pins_s.panel_mode_key, pins_s.panel_run_key, pins_s.panel_stop_key};
    mode_key_p  = pins_s.panel_mode_key & ~keys_prev_q[2];
    run_key_p   = pins_s.panel_run_key & ~keys_prev_q[1];
    stop_key_p  = pins_s.panel_stop_key & ~keys_prev_q[0];

    // error flags clear by writing one; a new event in the same cycle wins
    if (bus_i.wr && bus_i.addr == ADDR_ERROR)
    begin
      err_d = err_q & ~bus_i.wdata[ERR_W-1:0];
    end

    // mode change requests from the panel key or a serial mode code
    if (mode_key_p)
    begin
      req    = 1'b1;
      target = (mode_q == MODE_PANEL) ? MODE_TERM : MODE_PANEL;
    end
    else if (net_i.valid && net_i.kind == NET_KIND_MODE)
    begin
      req = 1'b1;
      case (net_i.data[1:0])
        NET_CODE_TERM:  target = MODE_TERM;
        NET_CODE_PANEL: target = MODE_PANEL;
        NET_CODE_NET:   target = MODE_NET;
        default:        req = 1'b0;
      endcase
      if (net_i.data[1:0] == 2'h3)
      begin
        err_d[ERR_MODE] = 1'b1;
      end
    end
    case (sel_q)
      SEL_TOGGLE:    allowed = 1'b1;
      SEL_TERM:      allowed = (target != MODE_PANEL);
      SEL_SWITCH:    allowed = 1'b1;
      SEL_INTERLOCK: allowed = pins_s.panel_interlock_input;
      default:       allowed = 1'b0;
    endcase
    // outside switchover mode the motor must be stopped to change mode
    if (sel_q != SEL_SWITCH && motor_running_i)
    begin
      allowed = 1'b0;
    end
    if (req)
    begin
      if (allowed)
      begin
        mode_d = target;
      end
      else
      begin
        err_d[ERR_MODE] = 1'b1;
      end
    end
    if (sel_q == SEL_INTERLOCK && !pins_s.panel_interlock_input)
    begin
      mode_d = MODE_TERM;
    end

    // register writes
    term_lock = (mode_q == MODE_TERM);
    if (bus_i.wr)
    begin
      if (bus_i.addr == ADDR_MODE_SEL)
      begin
        wr_sel = 1'b1;
      end
      else if (bus_i.addr == ADDR_STOP_CFG)
      begin
        stop_all_d = bus_i.wdata[STOP_ALL];
      end
      else if (bus_i.addr == ADDR_PANEL_SPD || bus_i.addr == ADDR_JOG_SPD
               || (bus_i.addr & ADDR_STEP_MASK) == ADDR_STEP_BASE)
      begin
        if (term_lock)
        begin
          err_d[ERR_LOCK] = 1'b1;
        end
        else if (bus_i.addr == ADDR_PANEL_SPD)
        begin
          panel_spd_d = bus_i.wdata[SPD_W-1:0];
        end
        else if (bus_i.addr == ADDR_JOG_SPD)
        begin
          jog_spd_d = bus_i.wdata[SPD_W-1:0];
        end
        else
        begin
          step_d[bus_i.addr[STEP_IDX_LSB+1:STEP_IDX_LSB]] = bus_i.wdata[SPD_W-1:0];
        end
      end
    end
    if (wr_sel)
    begin
      if (sel_legal(bus_i.wdata[2:0]) && bus_i.wdata[DATA_W-1:3] == '0
          && !motor_running_i)
      begin
        sel_d  = bus_i.wdata[2:0];
        mode_d = sel_mode(bus_i.wdata[2:0]);
      end
      else
      begin
        err_d[ERR_SEL] = 1'b1;
      end
    end

    // serial run and speed messages, taken in network mode, seen in panel mode
    net_ok = (mode_q == MODE_NET) || (mode_q == MODE_PANEL);
    if (net_i.valid && net_ok && mode_q == MODE_NET)
    begin
      if (net_i.kind == NET_KIND_RUN)
      begin
        net_fwd_d = net_i.data[0];
        net_rev_d = net_i.data[1];
      end
      else if (net_i.kind == NET_KIND_SPEED)
      begin
        net_spd_d = net_i.data;
      end
    end
    else if (net_i.valid && net_ok && net_i.kind == NET_KIND_SPEED)
    begin
      panel_spd_d = net_i.data;
    end

    // panel run keys latch a direction, the stop key drops it
    if (run_key_p)
    begin
      pnl_fwd_d = ~pins_s.panel_dir_rev;
      pnl_rev_d = pins_s.panel_dir_rev;
    end
    if (stop_key_p)
    begin
      pnl_fwd_d = 1'b0;
      pnl_rev_d = 1'b0;
    end

    // run source
    case (mode_q)
      MODE_TERM, MODE_COMB1:
      begin
        cmd_f = pins_s.forward_run_input;
        cmd_r = pins_s.reverse_run_input;
      end
      MODE_PANEL, MODE_COMB2:
      begin
        cmd_f = pnl_fwd_q;
        cmd_r = pnl_rev_q;
      end
      MODE_NET:
      begin
        cmd_f = net_fwd_q;
        cmd_r = net_rev_q;
      end
      default:
      begin
        cmd_f = 1'b0;
        cmd_r = 1'b0;
      end
    endcase
    // a stop from the panel holds until the selected run command is released
    stop_hold_d = stop_hold_q & (cmd_f | cmd_r);
    if (stop_key_p && (stop_all_q || mode_q == MODE_PANEL))
    begin
      stop_hold_d = 1'b1;
    end
    run_fwd_d = cmd_f & ~cmd_r & ~stop_hold_d;
    run_rev_d = cmd_r & ~cmd_f & ~stop_hold_d;

    // speed source
    steps    = {pins_s.speed_step_extra_input, pins_s.speed_step_high_input,
                pins_s.speed_step_mid_input, pins_s.speed_step_low_input};
    step_hit = |steps;
    for (int i = 0; i < STEP_N; i++)
    begin
      if (steps[i])
      begin
        step_idx = 2'(i);
      end
    end
    if (step_hit)
    begin
      term_spd = step_q[step_idx];
    end
    else if (pins_s.inching_input)
    begin
      term_spd = jog_spd_q;
    end
    else if (pins_s.analog_four_select_input)
    begin
      term_spd = analog_four_i;
    end
    else
    begin
      term_spd = analog_two_i;
    end
    if (step_hit)
    begin
      comb1_spd = step_q[step_idx];
    end
    else if (pins_s.process_loop_enable_input)
    begin
      comb1_spd = process_loop_speed_i;
    end
    else if (pins_s.analog_four_select_input)
    begin
      comb1_spd = analog_four_i;
    end
    else
    begin
      comb1_spd = panel_spd_q;
    end
    case (mode_q)
      MODE_TERM, MODE_COMB2: speed_d = term_spd;
      MODE_COMB1:            speed_d = comb1_spd;
      MODE_PANEL:            speed_d = panel_spd_q;
      MODE_NET:              speed_d = net_spd_q;
      default:               speed_d = SPD_RST;
    endcase

    // read data, valid in the cycle after the strobe
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        ADDR_MODE_SEL:  rd_data_d[2:0] = sel_q;
        ADDR_PANEL_SPD: rd_data_d[SPD_W-1:0] = panel_spd_q;
        ADDR_JOG_SPD:   rd_data_d[SPD_W-1:0] = jog_spd_q;
        ADDR_STOP_CFG:  rd_data_d[STOP_ALL] = stop_all_q;
        ADDR_STATUS:
        begin
          rd_data_d[ST_MODE_LSB+2:ST_MODE_LSB] = mode_q;
          rd_data_d[ST_FWD]                    = run_fwd_q;
          rd_data_d[ST_REV]                    = run_rev_q;
          rd_data_d[ST_STOP]                   = stop_hold_q;
          rd_data_d[ST_RUNNING]                = motor_running_i;
          rd_data_d[ST_SEL_LSB+2:ST_SEL_LSB]   = sel_q;
        end
        ADDR_ERROR:     rd_data_d[ERR_W-1:0] = err_q;
        default:
        begin
          if ((bus_i.addr & ADDR_STEP_MASK) == ADDR_STEP_BASE)
          begin
            rd_data_d[SPD_W-1:0] = step_q[bus_i.addr[STEP_IDX_LSB+1:STEP_IDX_LSB]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      keys_prev_q <= 3'h0;
      mode_q      <= MODE_TERM;
      sel_q       <= SEL_RST;
      panel_spd_q <= SPD_RST;
      jog_spd_q   <= SPD_RST;
      step_q      <= '{default: SPD_RST};
      stop_all_q  <= STOP_ALL_RST;
      err_q       <= '0;
      pnl_fwd_q   <= 1'b0;
      pnl_rev_q   <= 1'b0;
      net_fwd_q   <= 1'b0;
      net_rev_q   <= 1'b0;
      net_spd_q   <= SPD_RST;
      stop_hold_q <= 1'b0;
      run_fwd_q   <= 1'b0;
      run_rev_q   <= 1'b0;
      speed_q     <= SPD_RST;
      rd_data_q   <= '0;
    end
    else
    begin
      keys_prev_q <= keys_prev_d;
      mode_q      <= mode_d;
      sel_q       <= sel_d;
      panel_spd_q <= panel_spd_d;
      jog_spd_q   <= jog_spd_d;
      step_q      <= step_d;
      stop_all_q  <= stop_all_d;
      err_q       <= err_d;
      pnl_fwd_q   <= pnl_fwd_d;
      pnl_rev_q   <= pnl_rev_d;
      net_fwd_q   <= net_fwd_d;
      net_rev_q   <= net_rev_d;
      net_spd_q   <= net_spd_d;
      stop_hold_q <= stop_hold_d;
      run_fwd_q   <= run_fwd_d;
      run_rev_q   <= run_rev_d;
      speed_q     <= speed_d;
      rd_data_q   <= rd_data_d;
    end
  end

  assign op_mode_o   = mode_q;
  assign run_fwd_o   = run_fwd_q;
  assign run_rev_o   = run_rev_q;
  assign speed_ref_o = speed_q;
  assign rd_data_o   = rd_data_q;

endmodule

// ### dcs_source_select_sva.sv
// assertion checker for the drive command source selector
module dcs_source_select_sva (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire dcs_pkg::dcs_bus_req_t       bus_i,
  input  wire dcs_pkg::dcs_pins_t          pins_i,
  input  wire logic                        motor_running_i,
  input  wire dcs_pkg::dcs_net_msg_t       net_i,
  input  wire dcs_pkg::dcs_mode_t          op_mode_o,
  input  wire logic [dcs_pkg::SPD_W-1:0]   speed_ref_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcs_pkg::*;
  logic       ok_wr;
  logic [2:0] sel_d;
  logic [2:0] sel_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // mode select writes that must be accepted
  assign ok_wr = bus_i.wr && bus_i.addr == ADDR_MODE_SEL && bus_i.wdata[31:3] == '0
                 && bus_i.wdata[2:0] != 3'h5 && !motor_running_i;
  always_comb
  begin
    sel_d = sel_q;
    if (ok_wr)
      sel_d = bus_i.wdata[2:0];
  end
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      sel_q <= SEL_RST;
    else
      sel_q <= sel_d;
  end
  property p_start_term;
    ok_wr && !net_i.valid && (bus_i.wdata[2:0] == SEL_TOGGLE || bus_i.wdata[2:0] == SEL_TERM)
      |=> op_mode_o == MODE_TERM;
  endproperty
  a_start_term: assert property (p_start_term)
    else $error("select 0 or 2 gave no terminal mode");
  property p_panel_fixed;
    sel_q == SEL_PANEL && op_mode_o == MODE_PANEL && !(ok_wr && bus_i.wdata[2:0] != SEL_PANEL)
      |=> op_mode_o == MODE_PANEL;
  endproperty
  a_panel_fixed: assert property (p_panel_fixed)
    else $error("fixed panel mode left");
  property p_term_fixed;
    sel_q == SEL_TERM && !ok_wr |=> op_mode_o != MODE_PANEL;
  endproperty
  a_term_fixed: assert property (p_term_fixed)
    else $error("locked terminal mode reached panel");
  property p_comb;
    ok_wr && !net_i.valid && (bus_i.wdata[2:0] == SEL_COMB1 || bus_i.wdata[2:0] == SEL_COMB2)
      |=> op_mode_o == $past(bus_i.wdata[2:0]);
  endproperty
  a_comb: assert property (p_comb)
    else $error("combined mode not entered");
  property p_toggle;
    (!pins_i.panel_mode_key)[*3] ##0 (sel_q == SEL_TOGGLE && op_mode_o == MODE_TERM)
      ##1 (pins_i.panel_mode_key && sel_q == SEL_TOGGLE && !ok_wr && !net_i.valid
      && !motor_running_i)[*4] |-> op_mode_o == MODE_PANEL;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("mode key did not toggle to panel");
  property p_interlock;
    (sel_q == SEL_INTERLOCK && !pins_i.panel_interlock_input)[*4] |-> op_mode_o == MODE_TERM;
  endproperty
  a_interlock: assert property (p_interlock)
    else $error("interlock low without terminal mode");
  property p_net_mode;
    (!pins_i.panel_mode_key)[*3] ##0 (net_i.valid && net_i.kind == NET_KIND_MODE && !ok_wr
      && net_i.data[1:0] == NET_CODE_NET && sel_q == SEL_SWITCH) |=> op_mode_o == MODE_NET;
  endproperty
  a_net_mode: assert property (p_net_mode)
    else $error("serial mode code ignored");
  property p_net_speed;
    (op_mode_o == MODE_NET && net_i.valid && net_i.kind == NET_KIND_SPEED)
      ##1 (op_mode_o == MODE_NET && !net_i.valid) |=> speed_ref_o == $past(net_i.data, 2);
  endproperty
  a_net_speed: assert property (p_net_speed)
    else $error("serial speed not applied");
endmodule

bind dcs_source_select dcs_source_select_sva i_sva (.clock_i, .rst_i, .bus_i, .pins_i,
  .motor_running_i, .net_i, .op_mode_o, .speed_ref_o);

// ### dcs_net_master.sv
// serial network master model sending decoded messages
module dcs_net_master (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire logic                        send_i,
  input  wire logic [1:0]                  kind_i,
  input  wire logic [dcs_pkg::SPD_W-1:0]   data_i,
  input  wire logic                        slow_i,
  output dcs_pkg::dcs_net_msg_t            net_o,
  output logic                             busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcs_pkg::*;
  logic         pend_q;
  logic [1:0]   wait_q;
  dcs_net_msg_t msg_q;
  assign busy_o = pend_q;
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend_q <= 1'h0;
      wait_q <= 2'h0;
      msg_q  <= '0;
      net_o  <= '0;
    end
    else
    begin
      net_o.valid <= 1'h0;
      net_o.data  <= ~net_o.data; // idle line inverts its data every cycle
      if (send_i)
      begin
        pend_q <= 1'h1;
        wait_q <= slow_i ? 2'h3 : 2'h0;
        msg_q  <= '{1'h1, kind_i, data_i};
      end
      else if (pend_q && wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
      else if (pend_q)
      begin
        pend_q <= 1'h0;
        net_o  <= msg_q;
      end
    end
  end
endmodule

// ### dcs_source_select_tb.sv
// self-checking testbench for the drive command source selector
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module dcs_source_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcs_pkg::*;
  typedef struct packed {logic [1:0] src; logic [31:0] v;} dcs_exp_t;
  logic         clock_i;
  logic         rst_i;
  dcs_bus_req_t bus;
  dcs_pins_t    pins;
  dcs_net_msg_t net;
  logic         motor;
  logic [15:0]  a2, a4, pl, spd, r, ndat;
  logic [31:0]  rd_data;
  dcs_mode_t    op_mode;
  logic         fwd, rev, snd, slow, nbusy, probe;
  logic         rd_prev = 1'h0;
  logic [1:0]   knd;
  int           error_cnt, samples_checked, cyc;
  dcs_exp_t     exp_q[$];
  dcs_exp_t     e_h;
  logic [2:0]   sel_v [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  dcs_mode_t    mode_v [7] = '{MODE_TERM, MODE_PANEL, MODE_TERM, MODE_COMB1, MODE_COMB2,
                               MODE_TERM, MODE_TERM};
  dcs_source_select i_dut (.clock_i, .rst_i, .bus_i(bus), .rd_data_o(rd_data), .pins_i(pins),
    .motor_running_i(motor), .net_i(net), .analog_two_i(a2), .analog_four_i(a4),
    .process_loop_speed_i(pl), .op_mode_o(op_mode), .run_fwd_o(fwd), .run_rev_o(rev),
    .speed_ref_o(spd));
  dcs_net_master i_net (.clock_i, .rst_i, .send_i(snd), .kind_i(knd), .data_i(ndat),
    .slow_i(slow), .net_o(net), .busy_o(nbusy));
  initial
  begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus.wr    <= 1'h1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge clock_i);
    bus.wr    <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    bus.rd   <= 1'h1;
    bus.addr <= a;
    exp_q.push_back({2'h0, e});
    @(posedge clock_i);
    bus.rd   <= 1'h0;
  endtask
  // src 1 mode, 2 run pair, 3 speed
  task automatic chk(input logic [1:0] s, input logic [15:0] e);
    @(posedge clock_i);
    probe <= 1'h1;
    exp_q.push_back({s, 16'h0, e});
    @(posedge clock_i);
    probe <= 1'h0;
  endtask
  task automatic press(input int b);
    @(posedge clock_i);
    pins[b] <= 1'h1;
    idle(4);
    pins[b] <= 1'h0;
    idle(4);
  endtask
  task automatic send(input logic [1:0] k, input logic [15:0] d);
    int i;
    @(posedge clock_i);
    snd  <= 1'h1;
    knd  <= k;
    ndat <= d;
    slow <= 1'($urandom);
    @(posedge clock_i);
    snd  <= 1'h0;
    @(posedge clock_i);
    for (i = 0; nbusy && i < 20; i++)
      @(posedge clock_i);
    idle(3);
  endtask
  always @(posedge clock_i)
  begin
    rd_prev <= bus.rd;
    if (rd_prev || probe)
    begin
      e_h = exp_q.pop_front();
      case (e_h.src)
        2'h0: `CHK(rd_data, e_h.v)
        2'h1: `CHK(op_mode, e_h.v[2:0])
        2'h2: `CHK({fwd, rev}, e_h.v[1:0])
        default: `CHK(spd, e_h.v[15:0])
      endcase
    end
  end
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end
  initial
  begin
    void'($urandom(32'hE185D4CD));
    rst_i = 1'h1;
    bus = '0;
    pins = '0;
    motor = 1'h0;
    snd = 1'h0;
    knd = 2'h0;
    ndat = 16'h0;
    slow = 1'h0;
    probe = 1'h0;
    a2 = 16'($urandom);
    a4 = 16'($urandom);
    pl = 16'($urandom);
    r = 16'($urandom);
    repeat (5) @(posedge clock_i);
    rst_i <= 1'h0;
    rd(ADDR_MODE_SEL, 32'h0);
    rd(ADDR_STOP_CFG, 32'h1);
    rd(8'hFC, 32'h0);
    chk(2'h1, 16'(MODE_TERM));
    chk(2'h3, a2);
    pins.forward_run_input <= 1'h1;
    pins.speed_step_mid_input <= 1'h1;
    wr(ADDR_STEP_BASE + 8'h04, 32'(r));
    idle(3);
    chk(2'h2, 16'h2);
    chk(2'h3, SPD_RST);
    rd(ADDR_ERROR, 32'h2);
    wr(ADDR_ERROR, 32'h2);
    press(1);
    chk(2'h2, 16'h0);
    pins.forward_run_input <= 1'h0;
    pins.speed_step_mid_input <= 1'h0;
    motor <= 1'h1;
    wr(ADDR_MODE_SEL, 32'h1);
    motor <= 1'h0;
    chk(2'h1, 16'(MODE_TERM));
    wr(ADDR_MODE_SEL, 32'h5);
    wr(ADDR_MODE_SEL, 32'h9);
    rd(ADDR_MODE_SEL, 32'h0);
    rd(ADDR_ERROR, 32'h1);
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_MODE_SEL, 32'(sel_v[i]));
      chk(2'h1, 16'(mode_v[i]));
      rd(ADDR_STATUS, {21'h0, sel_v[i], 5'h0, mode_v[i]});
    end
    pins.panel_interlock_input <= 1'h1;
    send(NET_KIND_MODE, 16'(NET_CODE_PANEL));
    chk(2'h1, 16'(MODE_PANEL));
    pins.panel_interlock_input <= 1'h0;
    idle(3);
    chk(2'h1, 16'(MODE_TERM));
    wr(ADDR_MODE_SEL, 32'h6);
    motor <= 1'h1;
    send(NET_KIND_MODE, 16'(NET_CODE_NET));
    chk(2'h1, 16'(MODE_NET));
    send(NET_KIND_SPEED, r);
    chk(2'h3, r);
    send(NET_KIND_RUN, 16'h2);
    chk(2'h2, 16'h1);
    send(NET_KIND_MODE, 16'(NET_CODE_TERM));
    chk(2'h1, 16'(MODE_TERM));
    motor <= 1'h0;
    wr(ADDR_MODE_SEL, 32'h1);
    wr(ADDR_PANEL_SPD, 32'(a4));
    chk(2'h3, a4);
    press(3);
    send(NET_KIND_MODE, 16'(NET_CODE_NET));
    chk(2'h1, 16'(MODE_PANEL));
    send(NET_KIND_SPEED, pl);
    chk(2'h3, pl);
    rd(ADDR_ERROR, 32'h5);
    press(2);
    chk(2'h2, 16'h2);
    press(1);
    chk(2'h2, 16'h0);
    wr(ADDR_MODE_SEL, 32'h0);
    press(3);
    chk(2'h1, 16'(MODE_PANEL));
    press(3);
    chk(2'h1, 16'(MODE_TERM));
    wr(ADDR_MODE_SEL, 32'h2);
    press(3);
    chk(2'h1, 16'(MODE_TERM));
    wr(ADDR_MODE_SEL, 32'h3);
    wr(ADDR_PANEL_SPD, 32'(r));
    chk(2'h3, r);
    pins.analog_four_select_input <= 1'h1;
    idle(3);
    chk(2'h3, a4);
    pins.process_loop_enable_input <= 1'h1;
    idle(3);
    chk(2'h3, pl);
    r = 16'($urandom);
    wr(ADDR_STEP_BASE, 32'(r));
    pins.speed_step_low_input <= 1'h1;
    pins.forward_run_input <= 1'h1;
    idle(3);
    chk(2'h3, r);
    chk(2'h2, 16'h2);
    pins <= '0;
    wr(ADDR_MODE_SEL, 32'h4);
    chk(2'h3, a2);
    wr(ADDR_JOG_SPD, 32'(pl));
    pins.inching_input <= 1'h1;
    idle(3);
    chk(2'h3, pl);
    pins.panel_dir_rev <= 1'h1;
    press(2);
    chk(2'h2, 16'h1);
    finish_test();
  end
endmodule
